// file: hdl/sfr_pkg.sv
package sfr_pkg;
  localparam int         PIX_W        = 10;
  localparam int         CNT_W        = 16;
  localparam logic [15:0] HBLANK_RST  = 16'h015C;
  localparam logic [15:0] VBLANK_RST  = 16'h0020;
  localparam logic [15:0] EDGE_RST    = 16'h0006;
  localparam logic [15:0] DARK_ROWS   = 16'h000A;
  localparam logic [15:0] WIDTH_RST   = 16'h0640;
  localparam logic [15:0] HEIGHT_RST  = 16'h04B0;
  localparam logic [15:0] INTEG_RST   = 16'h0010;
  localparam logic [2:0]  DIV_RST     = 3'h1;
  localparam int         FIFO_DEPTH   = 8;
  typedef enum logic [2:0] {
    SFR_DARK  = 3'b000,
    SFR_LEAD  = 3'b001,
    SFR_ACT   = 3'b010,
    SFR_HBL   = 3'b011,
    SFR_TAIL  = 3'b100,
    SFR_VBL   = 3'b101
  } sfr_state_t;
endpackage

// file: hdl/sfr_readout.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Small FIFO holding pixels ahead of the output register.
// ****************************************
module sfr_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Fill side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;
  assign out_data  = mem[rp_r];

  // Storage is written without reset; only pointers and count need defined state.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ****************************************
// Frame and row timing generator.
// ****************************************
module sfr_readout (
  // Clock, reset and enable.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Pending settings, written by software.
  input  wire logic [15:0] hblank_a,
  input  wire logic [15:0] hblank_b,
  input  wire logic [15:0] frame_gap_setting_a,
  input  wire logic [15:0] frame_gap_setting_b,
  input  wire logic [3:0]  context_sel,
  input  wire logic        single_adc_a,
  input  wire logic        single_adc_b,
  input  wire logic [2:0]  clk_div,
  input  wire logic [2:0]  clk_delay,
  input  wire logic        skip_en,
  input  wire logic [1:0]  skip_mode,
  input  wire logic        binning_en,
  input  wire logic [15:0] col_width,
  input  wire logic [15:0] row_count,
  input  wire logic [15:0] edge_blank,
  input  wire logic [15:0] integ_rows,
  input  wire logic        integ_wr,
  input  wire logic [15:0] gain,
  input  wire logic        gain_wr,
  input  wire logic        hold_transfer,
  input  wire logic        show_bad,
  input  wire logic        show_dark,
  input  wire logic        bad_change,
  // Pixel source.
  input  wire logic [9:0]  pixel_in,
  output logic             pixel_req,
  // Stream to the consumer.
  output logic             pixel_clock_out,
  output logic             row_valid,
  output logic             frame_valid,
  output logic [9:0]       pixel_data,
  // Status.
  output logic             frame_start,
  output logic [15:0]      live_integ,
  output logic [15:0]      live_gain
);
  // Live copies of the double-buffered settings.
  logic [15:0] hbl_r;
  logic [15:0] vbl_r;
  logic        sadc_r;
  logic [2:0]  div_r;
  logic [4:0]  skip_r;
  logic [15:0] width_r;
  logic [15:0] height_r;
  logic [15:0] edge_r;
  logic [15:0] integ_r;
  logic [15:0] gain_r;
  logic [15:0] gain_defer_r;
  logic        gain_defer_v_r;
  logic        integ_pend_r;
  logic        gain_pend_r;
  logic        bad_pend_r;
  logic        mask_r;
  // Sequencer state.
  sfr_pkg::sfr_state_t st_r;
  sfr_pkg::sfr_state_t st_nxt;
  logic [15:0] pcnt_r;
  logic [15:0] rcnt_r;
  logic [31:0] ftick_r;
  logic [31:0] frame_len;
  logic        pop_en;
  logic [4:0]  div_cnt_r;
  logic        tick;
  logic [4:0]  period;
  logic [15:0] cols;
  logic [15:0] rows;
  logic [15:0] frame_rows;
  logic        fifo_v;
  logic [9:0]  fifo_d;
  logic        lv_int;
  logic        fv_int;
  logic [7:0]  ph_r;

  // Skip decode; binning adds one level of skip, except at skip mode 3 where the factor wraps to zero and nothing is skipped.
  function automatic logic [4:0] skip_of(input logic en, input logic [1:0] m, input logic bin);
    logic [4:0] s;
    s = en ? (5'h02 << m) : 5'h01;
    if (bin) begin
      s = en ? 5'(s << 1) : 5'h02;
    end
    return s;
  endfunction

  // Division by a power-of-two skip factor.
  function automatic logic [15:0] div_skip(input logic [15:0] v, input logic [4:0] s);
    logic [15:0] q;
    q = v;
    for (int i = 0; i < 5; i++) begin
      if (s[i]) begin
        q = v >> i;
      end
    end
    return q;
  endfunction

  // Pixel period in master clocks; a zero divider gives a period of one clock.
  assign period = (sadc_r ? {1'b0, div_r, 1'b0} : {2'b00, div_r}) | {4'h0, (div_r == 3'h0)};
  assign cols   = div_skip(width_r, skip_r);
  assign rows   = div_skip(height_r, skip_r);
  // Long integration stretches the frame by extending vertical blanking.
  assign frame_rows = (integ_r >= rows + vbl_r) ? integ_r : 16'(rows + vbl_r);
  // Whole frame length in pixel periods, counted from frame start.
  assign frame_len = 32'(frame_rows) * (32'(cols) + 32'(hbl_r));
  assign tick   = ce & (div_cnt_r == period - 5'h01);

  // Pixel period divider.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= '0;
    end else if (ce) begin
      div_cnt_r <= tick ? '0 : div_cnt_r + 5'h01;
    end
  end

  // Next-state logic of the row and frame sequencer.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      sfr_pkg::SFR_DARK: begin
        // Dark rows always run, so frame start sits ten rows ahead whether shown or not.
        if (rcnt_r == sfr_pkg::DARK_ROWS - 16'h0001 && pcnt_r == cols + hbl_r - 16'h0001) begin
          st_nxt = sfr_pkg::SFR_LEAD;
        end
      end
      sfr_pkg::SFR_LEAD: begin
        if (pcnt_r == edge_r - 16'h0001) begin
          st_nxt = sfr_pkg::SFR_ACT;
        end
      end
      sfr_pkg::SFR_ACT: begin
        if (pcnt_r == cols - 16'h0001) begin
          st_nxt = (rcnt_r == rows - 16'h0001) ? sfr_pkg::SFR_TAIL : sfr_pkg::SFR_HBL;
        end
      end
      sfr_pkg::SFR_HBL: begin
        if (pcnt_r == hbl_r - 16'h0001) begin
          st_nxt = sfr_pkg::SFR_ACT;
        end
      end
      sfr_pkg::SFR_TAIL: begin
        if (pcnt_r == edge_r - 16'h0001) begin
          st_nxt = sfr_pkg::SFR_VBL;
        end
      end
      sfr_pkg::SFR_VBL: begin
        if (ftick_r >= frame_len - 32'h00000001) begin
          st_nxt = sfr_pkg::SFR_DARK;
        end
      end
      default: st_nxt = sfr_pkg::SFR_DARK;
    endcase
  end

  // State, pixel counter and row counters, advanced once per pixel period.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= sfr_pkg::SFR_VBL;
      pcnt_r         <= '0;
      rcnt_r         <= '0;
      ftick_r        <= 32'hFFFFFFFF; // Ends the start-up blanking at the first tick.
    end else if (tick) begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        pcnt_r <= '0;
      end else if (st_r == sfr_pkg::SFR_DARK && pcnt_r == cols + hbl_r - 16'h0001) begin
        pcnt_r <= '0;
      end else begin
        pcnt_r <= pcnt_r + 16'h0001;
      end
      if (frame_start || (st_r == sfr_pkg::SFR_DARK && st_nxt != st_r)) begin
        rcnt_r <= '0;
      end else if ((st_r == sfr_pkg::SFR_DARK && pcnt_r == cols + hbl_r - 16'h0001) ||
                   (st_r == sfr_pkg::SFR_ACT && st_nxt == sfr_pkg::SFR_HBL)) begin
        rcnt_r <= rcnt_r + 16'h0001;
      end
      // Whole-frame timer; counting periods keeps the frame exact whatever the edge gaps are.
      ftick_r <= frame_start ? 32'h00000000 : ftick_r + 32'h00000001;
    end
  end

  // Frame start is the first dark row.
  assign frame_start = tick & (st_r == sfr_pkg::SFR_VBL) & (st_nxt == sfr_pkg::SFR_DARK);

  // Pending to live transfer; software never touches the live copies.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hbl_r    <= sfr_pkg::HBLANK_RST;
      vbl_r    <= sfr_pkg::VBLANK_RST;
      sadc_r   <= 1'b0;
      div_r    <= sfr_pkg::DIV_RST;
      skip_r   <= 5'h01;
      width_r  <= sfr_pkg::WIDTH_RST;
      height_r <= sfr_pkg::HEIGHT_RST;
      edge_r   <= sfr_pkg::EDGE_RST;
      integ_r  <= sfr_pkg::INTEG_RST;
    end else if (frame_start && !hold_transfer) begin
      hbl_r    <= context_sel[0] ? hblank_b : hblank_a;
      vbl_r    <= context_sel[1] ? frame_gap_setting_b : frame_gap_setting_a;
      sadc_r   <= context_sel[3] ? single_adc_b : single_adc_a;
      div_r    <= clk_div;
      skip_r   <= skip_of(skip_en, skip_mode, binning_en);
      width_r  <= col_width;
      height_r <= row_count;
      edge_r   <= (edge_blank == 16'h0000) ? 16'h0001 : edge_blank;
      integ_r  <= integ_rows;
    end
  end

  // Write flags; a write in the transfer cycle wins and stays pending.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_pend_r <= 1'b0;
      gain_pend_r  <= 1'b0;
      bad_pend_r   <= 1'b0;
    end else if (ce) begin
      integ_pend_r <= integ_wr | (integ_pend_r & ~(frame_start & ~hold_transfer));
      gain_pend_r  <= gain_wr | (gain_pend_r & ~(frame_start & ~hold_transfer));
      bad_pend_r   <= bad_change | (bad_pend_r & ~(frame_start & ~hold_transfer));
    end
  end

  // Gain goes live at frame start, held one more frame when integration moved too.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_r         <= '0;
      gain_defer_r   <= '0;
      gain_defer_v_r <= 1'b0;
    end else if (frame_start && !hold_transfer) begin
      if (gain_defer_v_r) begin
        gain_r <= gain_defer_r;
      end
      if (gain_pend_r && integ_pend_r) begin
        gain_defer_r   <= gain;
        gain_defer_v_r <= 1'b1;
      end else begin
        gain_defer_v_r <= 1'b0;
        if (gain_pend_r || !gain_defer_v_r) begin
          gain_r <= gain;
        end
      end
    end
  end

  // Frame mask for inconsistent integration, unless bad frames are shown.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 1'b0;
    end else if (frame_start) begin
      mask_r <= ((bad_pend_r && !hold_transfer) || (integ_pend_r && !hold_transfer)) && !show_bad;
    end
  end

  // Qualifiers before the output stage.
  assign fv_int = ~mask_r & (st_r == sfr_pkg::SFR_LEAD || st_r == sfr_pkg::SFR_ACT ||
                             st_r == sfr_pkg::SFR_HBL || st_r == sfr_pkg::SFR_TAIL ||
                             (show_dark && st_r == sfr_pkg::SFR_DARK));
  assign lv_int = ~mask_r & (st_r == sfr_pkg::SFR_ACT ||
                             (show_dark && st_r == sfr_pkg::SFR_DARK && pcnt_r < cols &&
                              rcnt_r != 16'h0000));
  // Fetch one period ahead so each active period pops the pixel fetched for it.
  assign pixel_req = tick & (st_nxt == sfr_pkg::SFR_ACT);
  assign pop_en    = tick & (st_r == sfr_pkg::SFR_ACT);

  // Pixel FIFO; in_ready is left open, so a full buffer does not stall the source.
  sfr_fifo #(
    .W (sfr_pkg::PIX_W),
    .D (sfr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (pixel_req),
    .in_ready  (),
    .in_data   (pixel_in),
    .out_valid (fifo_v),
    .out_ready (pop_en),
    .out_data  (fifo_d)
  );

  // Output register; one pixel per period while the row qualifier is high.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_valid   <= 1'b0;
      frame_valid <= 1'b0;
      pixel_data  <= '0;
    end else if (tick) begin
      row_valid   <= lv_int;
      frame_valid <= fv_int;
      pixel_data  <= (lv_int && fifo_v) ? fifo_d : '0;
    end
  end

  // Pixel clock phase history, stepped in whole master clocks, sampled on the rising edge only.
  // The clock runs whenever ce is high, blanking included, so the consumer may use it during blanking.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= '0;
    end else if (ce) begin
      ph_r <= {ph_r[6:0], (div_cnt_r >= (period >> 1))};
    end
  end

  // Delay selects a tap; odd settings invert for the half step, except at a one-clock period where the clock just toggles.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_clock_out <= 1'b0;
    end else if (ce) begin
      pixel_clock_out <= (period == 5'h01) ? ~pixel_clock_out ^ clk_delay[0] & 1'b0 :
                         ph_r[clk_delay >> 1] ^ clk_delay[0];
    end
  end

  assign live_integ = integ_r;
  assign live_gain  = gain_r;
endmodule

`default_nettype wire

// file: tb/sfr_readout_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checks for the readout block.
// ****
module sfr_readout_chk (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // Transfer controls.
  input wire logic [15:0] integ_rows,
  input wire logic        hold_transfer,
  // Stream and status.
  input wire logic        pixel_clock_out,
  input wire logic        row_valid,
  input wire logic        frame_valid,
  input wire logic        frame_start,
  input wire logic [15:0] live_integ,
  input wire logic [15:0] live_gain
);
  logic       pclk_q_r;
  logic [4:0] still_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Counts cycles since the pixel clock last moved; a gated clock lets it climb.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_q_r <= 1'b0;
      still_r  <= 5'h00;
    end else begin
      pclk_q_r <= pixel_clock_out;
      still_r  <= (!ce || pixel_clock_out != pclk_q_r) ? 5'h00 : still_r + 5'h01;
    end
  end
  a_clock_runs: assert property (still_r < 5'h10)
    else $error("pixel clock stopped");
  a_row_in_frame: assert property (row_valid |-> frame_valid)
    else $error("row qualifier outside frame");
  a_gap_lead: assert property ($rose(frame_valid) |-> !row_valid)
    else $error("row began with frame");
  a_gap_tail: assert property ($fell(frame_valid) |-> !$past(row_valid))
    else $error("frame ended with row");
  a_start_pulse: assert property (frame_start |=> !frame_start [*8])
    else $error("frame start too long");
  a_integ_moves: assert property ($changed(live_integ) |-> $past(frame_start))
    else $error("live integration moved off frame start");
  a_gain_moves: assert property ($changed(live_gain) |-> $past(frame_start))
    else $error("live gain moved off frame start");
  a_integ_taken: assert property (frame_start && !hold_transfer |=> live_integ == $past(integ_rows))
    else $error("integration not transferred");
  a_hold_blocks: assert property (frame_start && hold_transfer |=> $stable(live_integ) && $stable(live_gain))
    else $error("transfer while held");
  c_hold: cover property (frame_start && hold_transfer);
  c_frame_end: cover property ($fell(frame_valid));
  c_gain: cover property ($changed(live_gain));
endmodule
bind sfr_readout sfr_readout_chk chk_u (.core_clk, .rst_n, .ce, .integ_rows, .hold_transfer,
  .pixel_clock_out, .row_valid, .frame_valid, .frame_start, .live_integ, .live_gain);
`default_nettype wire

// file: tb/sfr_sink.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Stream consumer that also feeds the pixel source.
// ****
module sfr_sink (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Stream from the block.
  input  wire logic       pixel_req,
  input  wire logic       row_valid,
  input  wire logic       frame_valid,
  input  wire logic       frame_start,
  input  wire logic [9:0] pixel_data,
  // Source data and measured spans.
  output logic [9:0]      pixel_in,
  output int              act_len,
  output int              row_per,
  output int              rows,
  output int              fv_len,
  output int              lead,
  output int              pix_cnt,
  output int              seq_err
);
  logic       rv_r = 1'b0;
  logic       fv_r = 1'b0;
  logic [9:0] d_r  = 10'h000;
  logic [9:0] cnt_r = 10'h000;
  int         a_r, p_r, r_r, f_r, l_r, x_r;
  // Outside a fetch the source shows the inverse, so stale data is never taken.
  assign pixel_in = pixel_req ? cnt_r : ~cnt_r;
  // Each span counter restarts at its opening edge and is latched when it closes.
  always @(posedge core_clk) begin
    cnt_r <= !rst_n ? 10'h000 : cnt_r + {9'h000, pixel_req};
    rv_r <= row_valid;
    fv_r <= frame_valid;
    d_r <= pixel_data;
    a_r <= row_valid ? a_r + 1 : 0;
    p_r <= (row_valid && !rv_r) ? 1 : p_r + 1;
    f_r <= frame_valid ? f_r + 1 : 0;
    l_r <= frame_start ? 0 : l_r + 1;
    x_r <= (row_valid && !rv_r) ? 1 : x_r + int'(row_valid && pixel_data != d_r);
    if (row_valid && !rv_r && r_r > 0) row_per <= p_r;
    if (frame_valid && !fv_r) r_r <= 0;
    else if (row_valid && !rv_r) r_r <= r_r + 1;
    if (rv_r && !row_valid) begin
      act_len <= a_r;
      pix_cnt <= x_r;
    end
    if (fv_r && !frame_valid) begin
      fv_len <= f_r;
      rows <= r_r;
    end
    if (frame_valid && !fv_r) lead <= l_r;
    if (row_valid && rv_r && pixel_data != d_r && pixel_data != d_r + 10'h001) seq_err <= seq_err + 1;
  end
endmodule
`default_nettype wire

// file: tb/tb_sfr_readout.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench for the readout timing block.
// ****
module tb_sfr_readout;
  logic        core_clk, rst_n, integ_wr, gain_wr, hold_transfer, show_bad, show_dark, bad_change;
  logic        single_adc_b, skip_en, binning_en, pixel_req, pixel_clock_out, row_valid, frame_valid, frame_start;
  logic [15:0] hblank_a, hblank_b, gap_a, gap_b, col_width, row_count, edge_blank, integ_rows, gain;
  logic [15:0] live_integ, live_gain;
  logic [3:0]  context_sel;
  logic [2:0]  clk_div, clk_delay;
  logic [1:0]  skip_mode;
  logic [9:0]  pixel_in, pixel_data;
  int          act_len, row_per, rows, fv_len, lead, pix_cnt, seq_err, errors, tests_run, cyc;
  bit          seen;

  // The block under test.
  sfr_readout dut_u (.core_clk, .rst_n, .ce(1'b1), .hblank_a, .hblank_b, .frame_gap_setting_a(gap_a),
    .frame_gap_setting_b(gap_b), .context_sel, .single_adc_a(1'b0), .single_adc_b, .clk_div, .clk_delay,
    .skip_en, .skip_mode, .binning_en, .col_width, .row_count, .edge_blank, .integ_rows, .integ_wr, .gain,
    .gain_wr, .hold_transfer, .show_bad, .show_dark, .bad_change, .pixel_in, .pixel_req, .pixel_clock_out,
    .row_valid, .frame_valid, .pixel_data, .frame_start, .live_integ, .live_gain);
  // Consumer of the stream.
  sfr_sink sink_u (.core_clk, .rst_n, .pixel_req, .row_valid, .frame_valid, .frame_start, .pixel_data,
    .pixel_in, .act_len, .row_per, .rows, .fv_len, .lead, .pix_cnt, .seq_err);

  // Master clock at 20 MHz.
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic cmp_int(string nm, int e, int g);
    tests_run++;
    if (e != g) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic cmp16(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits for a frame start edge; a missing one ends the run.
  task automatic wait_fs;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (frame_start !== 1'b1 && k < 60000);
    if (k >= 60000) begin
      errors++;
      conclude();
    end
  endtask
  // Counts cycles up to the next frame start and notes any frame qualifier.
  task automatic next_frame;
    cyc = 0;
    seen = 0;
    do begin
      @(posedge core_clk);
      cyc++;
      if (frame_valid === 1'b1) seen = 1;
    end while (frame_start !== 1'b1 && cyc < 60000);
  endtask
  // Manual settings writes; no firmware runs in this bench.
  task automatic wr(bit wi, logic [15:0] vi, bit wg, logic [15:0] vg);
    @(posedge core_clk);
    if (wi) integ_rows <= vi;
    if (wg) gain <= vg;
    integ_wr <= wi;
    gain_wr <= wg;
    @(posedge core_clk);
    integ_wr <= 1'b0;
    gain_wr <= 1'b0;
  endtask
  // Measures one settled frame; row time r and frame time follow from the settings.
  task automatic run_frame(int px, int nr, int hb, int vb, int t, int p, int ig);
    int r;
    r = (px + hb) * t;
    wait_fs();
    next_frame();
    next_frame();
    cmp_int("frame cycles", ((ig >= nr + vb) ? ig : nr + vb) * r, cyc);
    cmp_int("active cycles", px * t, act_len);
    cmp_int("row cycles", r, row_per);
    cmp_int("rows", nr, rows);
    cmp_int("frame valid cycles", nr * r - hb * t + 2 * p * t, fv_len);
    cmp_int("lead cycles", 10 * r + t, lead);
    cmp_int("pixels per row", px, pix_cnt);
    cmp_int("frame shown", 1, seen);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the planned frame count.
  initial begin
    #(100000 * 50);
    errors++;
    conclude();
  end

  // Main sequence.
  initial begin
    {rst_n, integ_wr, gain_wr, hold_transfer, show_bad, show_dark, bad_change, skip_en, binning_en} = '0;
    single_adc_b = 1'b1;
    {hblank_a, hblank_b, gap_a, gap_b} = {16'h0008, 16'h0005, 16'h000C, 16'h000B};
    {col_width, row_count, edge_blank, integ_rows, gain} = {16'h0010, 16'h0004, 16'h0003, 16'h0002, 16'h0010};
    {context_sel, clk_div, clk_delay, skip_mode} = {4'h0, 3'h1, 3'h0, 2'h0};
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(1'b1, 16'h0002, 1'b0, 16'h0000);
    run_frame(16, 4, 8, 12, 1, 3, 2);
    show_dark <= 1'b1;
    wait_fs();
    next_frame();
    next_frame();
    cmp_int("dark frame cycles", 16 * 24, cyc);
    show_dark <= 1'b0;
    $display("test base timing done");
    skip_en <= 1'b1;
    row_count <= 16'h0020;
    for (int m = 0; m < 4; m++) begin
      skip_mode <= m[1:0];
      run_frame(16 >> (m + 1), 32 >> (m + 1), 8, 12, 1, 3, 2);
    end
    {context_sel, clk_div, clk_delay, skip_mode} <= {4'hB, 3'h2, 3'h3, 2'h0};
    binning_en <= 1'b1;
    edge_blank <= 16'h0002;
    run_frame(4, 8, 5, 11, 4, 2, 2);
    $display("test skip and context done");
    {context_sel, clk_div, clk_delay, skip_en, binning_en} <= {4'h0, 3'h1, 3'h0, 1'b0, 1'b0};
    row_count <= 16'h0004;
    edge_blank <= 16'h0003;
    wr(1'b1, 16'h0014, 1'b0, 16'h0000);
    run_frame(16, 4, 8, 12, 1, 3, 20);
    wr(1'b1, 16'h0003, 1'b0, 16'h0000);
    wait_fs();
    @(negedge core_clk);
    cmp16("live integration", 16'h0003, live_integ);
    next_frame();
    cmp_int("masked frame shown", 0, seen);
    show_bad <= 1'b1;
    bad_change <= 1'b1;
    @(posedge core_clk);
    bad_change <= 1'b0;
    next_frame();
    next_frame();
    cmp_int("bad frame shown", 1, seen);
    show_bad <= 1'b0;
    $display("test masking done");
    hold_transfer <= 1'b1;
    wr(1'b1, 16'h0005, 1'b0, 16'h0000);
    wait_fs();
    @(negedge core_clk);
    cmp16("held integration", 16'h0003, live_integ);
    @(posedge core_clk);
    hold_transfer <= 1'b0;
    wait_fs();
    @(negedge core_clk);
    cmp16("released integration", 16'h0005, live_integ);
    wr(1'b0, 16'h0000, 1'b1, 16'h0042);
    wait_fs();
    @(negedge core_clk);
    cmp16("live gain", 16'h0042, live_gain);
    wr(1'b1, 16'h0007, 1'b1, 16'h0055);
    wait_fs();
    @(negedge core_clk);
    cmp16("paired integration", 16'h0007, live_integ);
    cmp16("deferred gain", 16'h0042, live_gain);
    wait_fs();
    @(negedge core_clk);
    cmp16("paired gain", 16'h0055, live_gain);
    for (int v = 8; v < 11; v++) begin
      wr(1'b1, v[15:0], 1'b0, 16'h0000);
      wait_fs();
      @(negedge core_clk);
      cmp16("successive integration", v[15:0], live_integ);
    end
    cmp_int("pixel order errors", 0, seq_err);
    $display("test transfers done");
    conclude();
  end
endmodule
`default_nettype wire
